// ===== bench/rcc_air_model.sv
`timescale 1ns/1ps
module rcc_air_model (
  // Clock
  input wire logic pclk,
  // Channel conditions chosen by the bench
  input wire logic [7:0] energy,
  input wire logic frame,
  // Receiver side
  output logic [7:0] rssi = 8'h00,
  output logic rx_frame_valid = 1'b0,
  // Transmitter side
  input wire logic [7:0] tx_byte,
  input wire logic tx_byte_stb
);
  logic [7:0] got_q[$];
  always @(posedge pclk) begin
    rssi <= energy;
    rx_frame_valid <= frame;
  end
  // Every strobed byte went on air, header included.
  always @(posedge pclk) if (tx_byte_stb === 1'b1) got_q.push_back(tx_byte);
endmodule : rcc_air_model

// ===== bench/rcc_radio_ctrl_sva.sv
`timescale 1ns/1ps
module rcc_radio_ctrl_sva import rcc_pkg::*; #(
  parameter int CCA_SETTLE_CYC = CCA_CYC_DEF,
  parameter int FIFO_DEPTH = 16
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Radio
  input wire logic [11:0] lo_carrier_word_mhz,
  input wire logic rx_on,
  input wire logic tx_on,
  input wire logic cal_on,
  input wire logic [7:0] tx_power,
  input wire logic tx_byte_stb
);
  int cal_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_cnt <= 0;
    end else begin
      cal_cnt <= cal_on ? cal_cnt + 1 : 0;
    end
  end
  pulse_ready_a: assert property (pready |=> !pready) else $error("pready too long");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  power_write_a: assert property (pready && pwrite && paddr == A_TX_POWER
    |=> tx_power == $past(pwdata[7:0])) else $error("power register not applied");
  cal_before_tx_a: assert property ($rose(tx_on) |-> $past(cal_on))
    else $error("transmit without calibration");
  cal_length_a: assert property ($fell(cal_on) && (rx_on || tx_on) |-> cal_cnt == CAL_CYC)
    else $error("calibration length wrong");
  stb_needs_tx_a: assert property (tx_byte_stb |-> tx_on) else $error("byte while idle");
  stb_spacing_a: assert property (tx_byte_stb |=> !tx_byte_stb [*8])
    else $error("bytes too close");
  carrier_word_at_cal_a: assert property ($changed(lo_carrier_word_mhz) |-> $rose(cal_on))
    else $error("oscillator moved outside calibration");
endmodule : rcc_radio_ctrl_sva
bind rcc_radio_ctrl rcc_radio_ctrl_sva #(.CCA_SETTLE_CYC(CCA_SETTLE_CYC), .FIFO_DEPTH(FIFO_DEPTH))
  rcc_radio_ctrl_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .lo_carrier_word_mhz(lo_carrier_word_mhz), .rx_on(rx_on), .tx_on(tx_on), .cal_on(cal_on),
  .tx_power(tx_power), .tx_byte_stb(tx_byte_stb));

// ===== bench/test_radio_channel_cca_tx_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_radio_channel_cca_tx_test;
  import rcc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, frame = 0, rerr, ex;
  logic [7:0] paddr = 0, energy = 0, rssi, tx_power, tx_byte;
  logic [31:0] pwdata = 0, prdata, rdat, seed = 32'h2e3aea65;
  logic pready, pslverr, rx_frame_valid, rx_on, tx_on, cal_on, dac_override, tx_byte_stb;
  logic [11:0] lo_carrier_word_mhz;
  logic [15:0] dac_static;
  logic [7:0] exp_q[$];
  logic [7:0] b[4];
  int mismatches = 0, check_count = 0, w;
  rcc_radio_ctrl #(.CCA_SETTLE_CYC(16), .FIFO_DEPTH(16)) rcc_radio_ctrl_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_frame_valid,
    .rssi, .lo_carrier_word_mhz, .rx_on, .tx_on, .cal_on, .tx_power, .dac_override, .dac_static,
    .tx_byte, .tx_byte_stb);
  rcc_air_model rcc_air_model_inst (.pclk, .energy, .frame, .rssi, .rx_frame_valid, .tx_byte,
    .tx_byte_stb);
  initial forever #12.5 pclk = ~pclk;
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100) begin n++; @(posedge pclk); end
    if (n == 100) mismatches++;
    rdat = prdata; rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_mode(input bit tx);
    int n;
    n = 0;
    while (((tx ? tx_on : rx_on & ~cal_on) !== 1'b1) && n < 2000) begin n++; @(posedge pclk); end
    if (n == 2000) mismatches++;
  endtask : wait_mode
  task automatic cmp_bytes;
    int n;
    n = 0;
    while (rcc_air_model_inst.got_q.size() < exp_q.size() && n < 30000) begin
      n++;
      @(posedge pclk);
    end
    foreach (exp_q[i]) `CHK("tx_byte", exp_q[i], rcc_air_model_inst.got_q[i])
  endtask : cmp_bytes
  task automatic start_tx(input logic [2:0] cmd);
    rcc_air_model_inst.got_q.delete();
    apb(1, A_CMD, 32'(cmd));
    wait_mode(1);
  endtask : start_tx
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    #2000000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, A_TX_POWER, 0); `CHK("power_reset", 32'hff, rdat)
    apb(0, A_MODEM0, 0); `CHK("clear_condition_select_reset", 32'h3, rdat)
    apb(0, 8'h3c, 0); `CHK("unmapped_err", 1'b1, rerr)
    apb(1, A_TX_POWER, 32'h3); `CHK("power_port", 8'h03, tx_power)
    for (int k = 11; k <= 26; k++) begin
      w = 357 + 5 * (k - 11);
      apb(1, A_SYNTH_HI, 32'(w >> 8));
      apb(1, A_SYNTH_LO, 32'(w & 255));
      apb(1, A_CMD, 32'(CMD_RX_ON));
      `CHK("cal_start", 1'b1, cal_on)
      wait_mode(0);
      `CHK("rx_lo", 12'(2048 + w - 2), lo_carrier_word_mhz)
      apb(0, A_STATUS, 0);
      `CHK("rx_status", 4'h4, rdat[3:0])
      apb(1, A_CMD, 32'(CMD_RF_OFF));
    end
    energy <= 8'hec;
    apb(1, A_CMD, 32'(CMD_RX_ON)); wait_mode(0);
    apb(0, A_STATUS, 0); `CHK("clear_early", 1'b0, rdat[B_CLEAR])
    repeat (24) @(posedge pclk);
    for (int m = 1; m <= 3; m++) for (int c = 0; c < 4; c++) begin
      energy <= c[0] ? 8'h10 : 8'hec; frame <= c[1];
      apb(1, A_MODEM0, 32'(m)); repeat (8) @(posedge pclk);
      ex = m == 1 ? !c[0] : m == 2 ? !c[1] : !c[0] && !c[1];
      apb(0, A_STATUS, 0); `CHK("clear_status", ex, rdat[B_CLEAR])
      apb(1, A_IRQ, 1); apb(0, A_IRQ, 0); `CHK("clear_flag", ex, rdat[B_IRQ_CLEAR])
    end
    apb(1, A_CMD, 32'(CMD_TX_IF_CLEAR)); repeat (600) @(posedge pclk);
    apb(0, A_STATUS, 0); `CHK("busy_refused", 1'b0, rdat[B_TX_ACTIVE])
    energy <= 8'hec; frame <= 1'b0; repeat (8) @(posedge pclk);
    start_tx(CMD_TX_IF_CLEAR); apb(0, A_STATUS, 0); `CHK("clear_tx", 1'b1, rdat[B_TX_ACTIVE])
    apb(1, A_CMD, 32'(CMD_RF_OFF));
    seed = rnd(seed);
    w = int'(seed[9:0]);
    apb(1, A_SYNTH_HI, 32'(w >> 8)); apb(1, A_SYNTH_LO, 32'(w & 255)); apb(1, A_MODEM1, 32'(TM_CRC));
    start_tx(CMD_TX_ON); `CHK("tx_lo", 12'(2048 + w), lo_carrier_word_mhz)
    exp_q = {8'h00, 8'h00, 8'h00, 8'h00, SFD_BYTE, 8'h00, 8'h78, 8'hb8, 8'h4b};
    cmp_bytes();
    apb(1, A_CMD, 32'(CMD_RF_OFF));
    apb(1, A_MODEM1, 32'(TM_REPEAT)); apb(1, A_DAC_HI, 32'h18); apb(1, A_DAC_LO, 32'h0);
    start_tx(CMD_TX_ON); `CHK("dac_override", 1'b1, dac_override)
    `CHK("dac_static", 16'h1800, dac_static)
    apb(1, A_CMD, 32'(CMD_RF_OFF)); apb(1, A_DAC_HI, 32'h0);
    exp_q = {8'h00, 8'h00, 8'h00, 8'h00, SFD_BYTE};
    for (int i = 0; i < 4; i++) begin
      seed = rnd(seed);
      b[i] = seed[7:0];
      apb(1, A_QUEUE, 32'(b[i]));
    end
    exp_q = {exp_q, b[0], b[1], b[2], b[3], b[0], b[1], b[2], b[3]};
    start_tx(CMD_TX_ON); cmp_bytes();
    apb(1, A_CMD, 32'(CMD_RF_OFF));
    print_verdict();
  end
endmodule : test_radio_channel_cca_tx_test

// ===== hdl/rcc_fifo.sv
`timescale 1ns/1ps
module rcc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Streams
  rcc_stream_if.snk in_s,
  rcc_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("rcc_fifo: DEPTH must be a power of two >= 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire do_pop = out_s.valid && out_s.ready;
  wire do_push = in_s.valid && in_s.ready;

  // A full queue still accepts a word in the cycle it gives one away.
  assign in_s.ready = (count != (AW+1)'(DEPTH)) || do_pop;
  assign out_s.valid = (count != '0);
  assign out_s.data = mem[rd_ptr];

  always_ff @(posedge pclk) begin
    if (do_push) mem[wr_ptr] <= in_s.data;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : rcc_fifo

// ===== hdl/rcc_pkg.sv
package rcc_pkg;
  // Register byte offsets.
  localparam logic [7:0] A_SYNTH_HI = 8'h00;
  localparam logic [7:0] A_SYNTH_LO = 8'h04;
  localparam logic [7:0] A_MODEM0 = 8'h08;
  localparam logic [7:0] A_MODEM1 = 8'h0c;
  localparam logic [7:0] A_TX_POWER = 8'h10;
  localparam logic [7:0] A_DAC_HI = 8'h14;
  localparam logic [7:0] A_DAC_LO = 8'h18;
  localparam logic [7:0] A_CCA_THR = 8'h1c;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam logic [7:0] A_IRQ = 8'h24;
  localparam logic [7:0] A_CMD = 8'h28;
  localparam logic [7:0] A_QUEUE = 8'h2c;
  localparam logic [7:0] A_LO_CARRIER_WORD = 8'h30;
  // Status and flag bit positions.
  localparam int B_CLEAR = 0;
  localparam int B_TX_ACTIVE = 1;
  localparam int B_RX_ON = 2;
  localparam int B_CAL = 3;
  localparam int B_IRQ_CLEAR = 0;
  // Reset values.
  localparam logic [7:0] RST_TX_POWER = 8'hff;
  localparam logic [7:0] RST_CCA_THR = 8'h00;
  localparam logic [1:0] RST_CLEAR_CONDITION_SELECT = 2'h3;
  // Command strobe codes.
  localparam logic [2:0] CMD_RX_ON = 3'h1;
  localparam logic [2:0] CMD_TX_ON = 3'h2;
  localparam logic [2:0] CMD_TX_IF_CLEAR = 3'h3;
  localparam logic [2:0] CMD_RF_OFF = 3'h4;
  // Clear channel condition select codes.
  localparam logic [1:0] CC_RESERVED = 2'h0;
  localparam logic [1:0] CC_ENERGY = 2'h1;
  localparam logic [1:0] CC_NO_FRAME = 2'h2;
  localparam logic [1:0] CC_BOTH = 2'h3;
  // Transmit mode codes.
  localparam logic [1:0] TM_REPEAT = 2'h2;
  localparam logic [1:0] TM_CRC = 2'h3;
  // Carrier arithmetic in MHz.
  localparam logic [11:0] CARRIER_BASE_MHZ = 12'h800;
  localparam logic [11:0] RX_IF_MHZ = 12'h002;
  // Synchronisation header: preamble bytes then delimiter.
  localparam logic [2:0] PREAMBLE_BYTES = 3'h4;
  localparam logic [2:0] SHR_BYTES = 3'h5;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h00;
  localparam logic [7:0] SFD_BYTE = 8'ha7;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [7:0] CRC_FILL = 8'hff;
  // Timing.
  localparam int CLK_MHZ = 40;
  localparam int SYMBOL_NS = 16000;
  localparam int CCA_SYMBOLS = 8;
  localparam int CAL_NS = 12000;
  localparam int BYTE_NS = 32000;
  localparam int CCA_CYC_DEF = (CCA_SYMBOLS * SYMBOL_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_CYC = (CAL_NS * CLK_MHZ + 999) / 1000;
  localparam int BYTE_CYC = (BYTE_NS * CLK_MHZ) / 1000;
endpackage : rcc_pkg

// ===== hdl/rcc_radio_ctrl.sv
// Contract
// - Ten-bit word sets carrier 2048 plus word
// - Receive oscillator sits 2 MHz below carrier
// - Mode 00 reserved, 01 energy below threshold
// - Mode 10: clear when no valid frame
// - Mode 11: low energy and no frame
// - Result valid after eight receive symbol periods
// - Clear status bit and interrupt flag set
// - Transmit-if-clear starts only on clear channel
// - Every receive or transmit enable calibrates
// - Output power from eight-bit transmit register
// - Mode 2 with DAC word: static DACs
// - Mode 3 sends CRC low byte, fills 0xFF
// - CRC sequence spans 65535 bits from 0x00
// - Every transmission starts with synchronisation header
// - Mode 2 repeats queue contents ignoring underflow
`timescale 1ns/1ps
module rcc_radio_ctrl import rcc_pkg::*; #(
  parameter int CCA_SETTLE_CYC = CCA_CYC_DEF,
  parameter int FIFO_DEPTH = 16
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver pins
  input wire logic rx_frame_valid,
  input wire logic [7:0] rssi,
  // Synthesizer and transmitter
  output logic [11:0] lo_carrier_word_mhz,
  output logic rx_on,
  output logic tx_on,
  output logic cal_on,
  output logic [7:0] tx_power,
  output logic dac_override,
  output logic [15:0] dac_static,
  output logic [7:0] tx_byte,
  output logic tx_byte_stb
);
  if (CCA_SETTLE_CYC < 1 || CCA_SETTLE_CYC > 65535) begin : g_bad_settle
    $error("rcc_radio_ctrl: bad CCA_SETTLE_CYC");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_RX_CAL, ST_RX, ST_TX_CAL, ST_TX} rcc_state_t;

  localparam logic [15:0] CCA_SETTLE = 16'(CCA_SETTLE_CYC);
  localparam logic [10:0] CAL_LAST = 11'(CAL_CYC - 1);
  localparam logic [10:0] BYTE_LAST = 11'(BYTE_CYC - 1);

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_upd

  rcc_state_t state;
  rcc_state_t next_state;
  logic [1:0] carrier_word_hi;
  logic [7:0] carrier_word_lo;
  logic [1:0] clear_condition_select;
  logic [1:0] tx_mode;
  logic [7:0] dac_hi;
  logic [7:0] dac_lo;
  logic [7:0] cca_thr;
  logic irq_clear;
  logic chan_clear;
  logic [10:0] cal_cnt;
  logic [15:0] rx_cnt;
  logic [10:0] byte_cnt;
  logic [2:0] shr_idx;
  logic [15:0] crc;
  logic frame_m;
  logic frame_s;
  logic [7:0] rssi_m;
  logic [7:0] rssi_s;

  rcc_stream_if #(.W(8)) q_in ();
  rcc_stream_if #(.W(8)) q_out ();

  rcc_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_queue (
    .pclk(pclk),
    .presetn(presetn),
    .in_s(q_in),
    .out_s(q_out)
  );

  // Bus decode.
  logic addr_hit;
  logic [31:0] rd_mux;
  wire access = psel && penable;
  wire wr_en = access && pready && pwrite && addr_hit;
  wire wr_cmd = wr_en && (paddr == A_CMD);
  wire [2:0] cmd = pwdata[2:0];
  wire queue_wr = access && pwrite && (paddr == A_QUEUE);
  wire [9:0] carrier_word = {carrier_word_hi, carrier_word_lo};
  wire [11:0] carrier_mhz = CARRIER_BASE_MHZ + {2'h0, carrier_word};
  wire tx_active = (state == ST_TX_CAL) || (state == ST_TX);
  wire [3:0] status = {cal_on, rx_on, tx_active, chan_clear};
  wire repeat_run = (state == ST_TX) && (tx_mode == TM_REPEAT);
  wire stall = queue_wr && (!q_in.ready || repeat_run);

  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h0;
    if (paddr == A_SYNTH_HI) begin
      rd_mux = {30'h0, carrier_word_hi};
    end else if (paddr == A_SYNTH_LO) begin
      rd_mux = {24'h0, carrier_word_lo};
    end else if (paddr == A_MODEM0) begin
      rd_mux = {30'h0, clear_condition_select};
    end else if (paddr == A_MODEM1) begin
      rd_mux = {30'h0, tx_mode};
    end else if (paddr == A_TX_POWER) begin
      rd_mux = {24'h0, tx_power};
    end else if (paddr == A_DAC_HI) begin
      rd_mux = {24'h0, dac_hi};
    end else if (paddr == A_DAC_LO) begin
      rd_mux = {24'h0, dac_lo};
    end else if (paddr == A_CCA_THR) begin
      rd_mux = {24'h0, cca_thr};
    end else if (paddr == A_STATUS) begin
      rd_mux = {28'h0, status};
    end else if (paddr == A_IRQ) begin
      rd_mux = {31'h0, irq_clear};
    end else if (paddr == A_LO_CARRIER_WORD) begin
      rd_mux = {20'h0, lo_carrier_word_mhz};
    end else if (paddr == A_CMD || paddr == A_QUEUE) begin
      rd_mux = 32'h0;
    end else begin
      addr_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= access && !pready && !stall;
      pslverr <= access && !pready && !stall && !addr_hit;
      if (access && !pready) prdata <= pwrite ? 32'h0 : rd_mux;
    end
  end

  // Configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_word_hi <= 2'h0;
      carrier_word_lo <= 8'h00;
      clear_condition_select <= RST_CLEAR_CONDITION_SELECT;
      tx_mode <= 2'h0;
      tx_power <= RST_TX_POWER;
      dac_hi <= 8'h00;
      dac_lo <= 8'h00;
      cca_thr <= RST_CCA_THR;
    end else if (wr_en) begin
      if (paddr == A_SYNTH_HI) carrier_word_hi <= pwdata[1:0];
      if (paddr == A_SYNTH_LO) carrier_word_lo <= pwdata[7:0];
      if (paddr == A_MODEM0) clear_condition_select <= pwdata[1:0];
      if (paddr == A_MODEM1) tx_mode <= pwdata[1:0];
      if (paddr == A_TX_POWER) tx_power <= pwdata[7:0];
      if (paddr == A_DAC_HI) dac_hi <= pwdata[7:0];
      if (paddr == A_DAC_LO) dac_lo <= pwdata[7:0];
      if (paddr == A_CCA_THR) cca_thr <= pwdata[7:0];
    end
  end

  // Receiver pins cross into the bus clock domain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_m <= 1'b0;
      frame_s <= 1'b0;
      rssi_m <= 8'h00;
      rssi_s <= 8'h00;
    end else begin
      frame_m <= rx_frame_valid;
      frame_s <= frame_m;
      rssi_m <= rssi;
      rssi_s <= rssi_m;
    end
  end

  // Clear channel assessment.
  wire energy_low = $signed(rssi_s) < $signed(cca_thr);
  wire cca_valid = (state == ST_RX) && (rx_cnt == CCA_SETTLE);
  wire cond_energy = (clear_condition_select == CC_ENERGY) && energy_low;
  wire cond_frame = (clear_condition_select == CC_NO_FRAME) && !frame_s;
  wire cond_both = (clear_condition_select == CC_BOTH) && energy_low && !frame_s;
  wire next_clear = cca_valid && (cond_energy || cond_frame || cond_both);

  // Transmit byte timing and sources.
  wire byte_tick = (state == ST_TX) && (byte_cnt == BYTE_LAST);
  wire in_shr = (shr_idx != SHR_BYTES);
  wire payload_tick = byte_tick && !in_shr;
  wire crc_mode = (tx_mode == TM_CRC);
  wire tx_end = payload_tick && !crc_mode && !repeat_run && !q_out.valid;
  wire [7:0] shr_byte = (shr_idx < PREAMBLE_BYTES) ? PREAMBLE_BYTE : SFD_BYTE;

  assign q_out.ready = payload_tick && !crc_mode;
  assign q_in.valid = (q_out.valid && q_out.ready && repeat_run) || (wr_en && paddr == A_QUEUE);
  assign q_in.data = repeat_run ? q_out.data : pwdata[7:0];

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (wr_cmd && cmd == CMD_RX_ON) next_state = ST_RX_CAL;
        else if (wr_cmd && cmd == CMD_TX_ON) next_state = ST_TX_CAL;
      end
      ST_RX_CAL: begin
        if (cal_cnt == CAL_LAST) next_state = ST_RX;
      end
      ST_RX: begin
        if (wr_cmd && cmd == CMD_TX_ON) next_state = ST_TX_CAL;
        else if (wr_cmd && cmd == CMD_TX_IF_CLEAR && chan_clear) next_state = ST_TX_CAL;
      end
      ST_TX_CAL: begin
        if (cal_cnt == CAL_LAST) next_state = ST_TX;
      end
      ST_TX: begin
        if (tx_end) next_state = ST_RX_CAL;
      end
      default: next_state = ST_IDLE;
    endcase
    if (wr_cmd && cmd == CMD_RF_OFF) next_state = ST_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cal_cnt <= 11'h0;
      rx_cnt <= 16'h0;
      lo_carrier_word_mhz <= 12'h0;
    end else begin
      state <= next_state;
      cal_cnt <= (next_state != state) ? 11'h0 : cal_cnt + 11'h1;
      if (next_state != ST_RX) rx_cnt <= 16'h0;
      else if (rx_cnt != CCA_SETTLE) rx_cnt <= rx_cnt + 16'h1;
      // The word is sampled only on entry to calibration.
      if (next_state == ST_RX_CAL && state != ST_RX_CAL)
        lo_carrier_word_mhz <= carrier_mhz - RX_IF_MHZ;
      else if (next_state == ST_TX_CAL && state != ST_TX_CAL)
        lo_carrier_word_mhz <= carrier_mhz;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_clear <= 1'b0;
      irq_clear <= 1'b0;
      rx_on <= 1'b0;
      tx_on <= 1'b0;
      cal_on <= 1'b0;
      dac_override <= 1'b0;
      dac_static <= 16'h0;
    end else begin
      chan_clear <= next_clear;
      // A new event wins over a write-one clear in the same cycle.
      if (next_clear) irq_clear <= 1'b1;
      else if (wr_en && paddr == A_IRQ && pwdata[B_IRQ_CLEAR]) irq_clear <= 1'b0;
      rx_on <= (next_state == ST_RX_CAL) || (next_state == ST_RX);
      tx_on <= (next_state == ST_TX);
      cal_on <= (next_state == ST_RX_CAL) || (next_state == ST_TX_CAL);
      dac_override <= (next_state == ST_TX) && (tx_mode == TM_REPEAT)
                      && ({dac_hi, dac_lo} != 16'h0);
      dac_static <= {dac_hi, dac_lo};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_cnt <= 11'h0;
      shr_idx <= 3'h0;
      crc <= 16'h0;
      tx_byte <= 8'h00;
      tx_byte_stb <= 1'b0;
    end else begin
      // No strobe on the byte slot where the transmitter is being left.
      tx_byte_stb <= byte_tick && (next_state == ST_TX);
      if (state != ST_TX) begin
        byte_cnt <= 11'h0;
        shr_idx <= 3'h0;
        crc <= 16'h0;
      end else begin
        byte_cnt <= byte_tick ? 11'h0 : byte_cnt + 11'h1;
        if (byte_tick && in_shr) begin
          tx_byte <= shr_byte;
          shr_idx <= shr_idx + 3'h1;
        end else if (payload_tick && crc_mode) begin
          tx_byte <= crc[7:0];
          crc <= crc_upd(crc, CRC_FILL);
        end else if (payload_tick) begin
          tx_byte <= q_out.valid ? q_out.data : 8'h00;
        end
      end
    end
  end
endmodule : rcc_radio_ctrl

// ===== hdl/rcc_stream_if.sv
`timescale 1ns/1ps
interface rcc_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : rcc_stream_if
